// File: src/rtcptc_top.sv
`timescale 1ns/1ps
module rtcptc_top #(
  parameter int SECOND_CYCLES = rtcptc_pkg::SECOND_CYCLES
) (
  input  wire logic                           clk,
  input  wire logic                           rst,
  input  wire rtcptc_pkg::rtcptc_req_t        req,
  output logic [rtcptc_pkg::DATA_W-1:0]       rdata,
  output logic                                irq_to_cpu,
  output logic [1:0]                          irq_priority,
  output logic                                converter_trigger,
  output logic                                converter_comparator_enable
);
  rtcptc_pkg::rtcptc_ctrl_t ctrl_r;
  logic [31:0]              presc_r;
  logic [5:0]               sec_in_min_r;
  logic [31:0]              seconds_r;
  logic [31:0]              count_view_r;
  logic                     flag_r;
  logic                     wait_status_r;
  logic                     tick_sec;
  logic                     tick_half;
  logic                     periodic_evt;
  logic                     counting;
  logic                     wr_ctrl;
  logic                     wr_status;

  assign wr_ctrl   = req.wr && req.addr == rtcptc_pkg::OFF_CTRL;
  assign wr_status = req.wr && req.addr == rtcptc_pkg::OFF_STATUS;
  // no gate, no clock: the whole timebase is frozen, not just the output
  assign counting  = ctrl_r.timekeeper_clock_gate && ctrl_r.timekeeper_run;
  assign tick_sec  = counting && presc_r == 32'(SECOND_CYCLES - 1);
  assign tick_half = counting && presc_r == 32'(SECOND_CYCLES / 2 - 1);

  always_comb begin
    case (ctrl_r.periodic_irq_period_sel)
      rtcptc_pkg::PERIOD_HALF:   periodic_evt = tick_sec || tick_half;
      rtcptc_pkg::PERIOD_SECOND: periodic_evt = tick_sec;
      rtcptc_pkg::PERIOD_MINUTE: periodic_evt = tick_sec
                                 && sec_in_min_r == 6'(rtcptc_pkg::SEC_PER_MIN - 1);
      default:                   periodic_evt = 1'b0;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_r <= rtcptc_pkg::rtcptc_ctrl_t'(rtcptc_pkg::CTRL_RESET);
    end else if (wr_ctrl) begin
      ctrl_r <= rtcptc_pkg::rtcptc_ctrl_t'(req.wdata[11:0]);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      presc_r      <= 32'h0000_0000;
      sec_in_min_r <= 6'h00;
      seconds_r    <= 32'h0000_0000;
    end else if (tick_sec) begin
      presc_r      <= 32'h0000_0000;
      seconds_r    <= seconds_r + 32'h0000_0001;
      sec_in_min_r <= (sec_in_min_r == 6'(rtcptc_pkg::SEC_PER_MIN - 1)) ? 6'h00
                                                                     : sec_in_min_r + 6'h01;
    end else if (counting) begin
      presc_r <= presc_r + 32'h0000_0001;
    end
  end

  // the wait handshake needs the timekeeper clock to answer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wait_status_r <= 1'b0;
    end else if (ctrl_r.timekeeper_clock_gate) begin
      wait_status_r <= ctrl_r.counter_wait_request;
    end
  end

  // software sees a stable copy while waiting, so multi-field reads agree
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_view_r <= 32'h0000_0000;
    end else if (!wait_status_r) begin
      count_view_r <= seconds_r;
    end
  end

  // a new event in the clearing cycle wins over the clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flag_r <= 1'b0;
    end else if (periodic_evt) begin
      flag_r <= 1'b1;
    end else if (wr_status && !req.wdata[rtcptc_pkg::STAT_FLAG_BIT]) begin
      flag_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_to_cpu        <= 1'b0;
      irq_priority      <= 2'h0;
      converter_trigger <= 1'b0;
    end else begin
      irq_to_cpu        <= flag_r && !ctrl_r.timekeeper_irq_mask;
      irq_priority      <= {ctrl_r.timekeeper_irq_priority_hi,
                            ctrl_r.timekeeper_irq_priority_lo};
      converter_trigger <= periodic_evt && ctrl_r.converter_trigger_source_sel
                           == rtcptc_pkg::TRIG_TIMEKEEPER;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      converter_comparator_enable <= 1'b0;
    end else begin
      converter_comparator_enable <= ctrl_r.converter_comparator_enable;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= '0;
    end else if (req.rd) begin
      case (req.addr)
        rtcptc_pkg::OFF_CTRL:   rdata <= {20'h00000, ctrl_r};
        rtcptc_pkg::OFF_STATUS: rdata <= {30'h0000_0000, wait_status_r, flag_r};
        rtcptc_pkg::OFF_COUNT:  rdata <= count_view_r;
        default:                rdata <= '0;
      endcase
    end else begin
      rdata <= '0;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_gate_off_freeze;
    !ctrl_r.timekeeper_clock_gate |=> $stable(presc_r) && $stable(seconds_r);
  endproperty
  a_gate_off_freeze: assert property (p_gate_off_freeze) else $error("ungated count");

  property p_second_evt;
    ctrl_r.periodic_irq_period_sel == rtcptc_pkg::PERIOD_SECOND && counting
      && presc_r == 32'(SECOND_CYCLES - 1) |-> periodic_evt ##1 flag_r;
  endproperty
  a_second_evt: assert property (p_second_evt) else $error("second event missing");

  property p_priority;
    wr_ctrl && req.wdata[5:4] == 2'h3 |=> ##1 irq_priority == 2'h3;
  endproperty
  a_priority: assert property (p_priority) else $error("priority not level 3");

  property p_flag_clear;
    wr_status && !req.wdata[0] && !periodic_evt |=> !flag_r;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");

  property p_forward;
    flag_r && !ctrl_r.timekeeper_irq_mask |=> irq_to_cpu;
  endproperty
  a_forward: assert property (p_forward) else $error("request not forwarded");

  property p_mask_trig;
    periodic_evt && ctrl_r.timekeeper_irq_mask
      && ctrl_r.converter_trigger_source_sel == rtcptc_pkg::TRIG_TIMEKEEPER
      |=> converter_trigger && !irq_to_cpu;
  endproperty
  a_mask_trig: assert property (p_mask_trig) else $error("mask handling wrong");

  property p_run_counts;
    counting && !tick_sec |=> presc_r == $past(presc_r) + 32'h0000_0001;
  endproperty
  a_run_counts: assert property (p_run_counts) else $error("run did not count");

  property p_wait_set;
    ctrl_r.timekeeper_clock_gate && ctrl_r.counter_wait_request
      && $stable(ctrl_r) |=> wait_status_r;
  endproperty
  a_wait_set: assert property (p_wait_set) else $error("wait status not set");

  property p_wait_clr;
    ctrl_r.timekeeper_clock_gate && !ctrl_r.counter_wait_request
      && $stable(ctrl_r) |=> !wait_status_r;
  endproperty
  a_wait_clr: assert property (p_wait_clr) else $error("wait status not cleared");

  property p_trig_route;
    converter_trigger |-> $past(periodic_evt)
      && $past(ctrl_r.converter_trigger_source_sel) == rtcptc_pkg::TRIG_TIMEKEEPER;
  endproperty
  a_trig_route: assert property (p_trig_route) else $error("bad trigger source");

  property p_freeze_view;
    wait_status_r ##1 wait_status_r |-> $stable(count_view_r);
  endproperty
  a_freeze_view: assert property (p_freeze_view) else $error("view changed in wait");

  // set wins over a clear in the same cycle, so an event is never lost
  property p_flag_set;
    periodic_evt |=> flag_r;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not set");

  property p_mask_block;
    ctrl_r.timekeeper_irq_mask |=> !irq_to_cpu;
  endproperty
  a_mask_block: assert property (p_mask_block) else $error("masked irq forwarded");

  property p_stop_hold;
    ctrl_r.timekeeper_clock_gate && !ctrl_r.timekeeper_run
      |=> $stable(presc_r) && !converter_trigger;
  endproperty
  a_stop_hold: assert property (p_stop_hold) else $error("stopped counter moved");

  property p_wait_gate_off;
    !ctrl_r.timekeeper_clock_gate |=> $stable(wait_status_r);
  endproperty
  a_wait_gate_off: assert property (p_wait_gate_off) else $error("wait moved ungated");

  property p_trig_sel_off;
    ctrl_r.converter_trigger_source_sel != rtcptc_pkg::TRIG_TIMEKEEPER |=> !converter_trigger;
  endproperty
  a_trig_sel_off: assert property (p_trig_sel_off) else $error("stray trigger");

  property p_evt_gated;
    !counting |-> !periodic_evt;
  endproperty
  a_evt_gated: assert property (p_evt_gated) else $error("event while stopped");

  c_trigger:  cover property (converter_trigger);
  c_irq:      cover property (irq_to_cpu);
  c_wait:     cover property (wait_status_r ##[1:20] !wait_status_r);
  c_clr_race: cover property (periodic_evt && wr_status && !req.wdata[0]);
  c_half:     cover property (periodic_evt && tick_half);
endmodule : rtcptc_top

// File: pkg/rtcptc_pkg.sv
package rtcptc_pkg;
  localparam int          ADDR_W          = 4;
  localparam int          DATA_W          = 32;
  localparam logic [3:0]  OFF_CTRL        = 4'h0;
  localparam logic [3:0]  OFF_STATUS      = 4'h4;
  localparam logic [3:0]  OFF_COUNT       = 4'h8;
  localparam int          STAT_FLAG_BIT   = 0;
  localparam int          STAT_WAIT_BIT   = 1;
  localparam logic [2:0]  PERIOD_HALF     = 3'h1;
  localparam logic [2:0]  PERIOD_SECOND   = 3'h2;
  localparam logic [2:0]  PERIOD_MINUTE   = 3'h3;
  localparam logic [1:0]  TRIG_TIMEKEEPER = 2'h2;
  localparam logic [11:0] CTRL_RESET      = 12'h000;
  localparam logic [5:0]  SEC_PER_MIN     = 6'h3C;
  localparam longint      SECOND_NS       = 1000000000;
  localparam longint      CLK_PERIOD_NS   = 50;
  localparam int          SECOND_CYCLES   = int'(SECOND_NS / CLK_PERIOD_NS);

  // control register, bit 11 downward
  typedef struct packed {
    logic       converter_comparator_enable;
    logic [1:0] converter_trigger_source_sel;
    logic [2:0] periodic_irq_period_sel;
    logic       timekeeper_irq_priority_hi;
    logic       timekeeper_irq_priority_lo;
    logic       timekeeper_irq_mask;
    logic       counter_wait_request;
    logic       timekeeper_run;
    logic       timekeeper_clock_gate;
  } rtcptc_ctrl_t;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } rtcptc_req_t;
endpackage : rtcptc_pkg

// File: testbench/rtcptc_adc_model.sv
`timescale 1ns/1ps
module rtcptc_adc_model (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic trigger,
  input  wire logic comparator_enable,
  output int        conv_count
);
  // a trigger with the comparator off is lost, as on the real converter
  always_ff @(posedge clk or posedge rst) begin
    if (rst) conv_count <= 0;
    else if (trigger && comparator_enable) conv_count <= conv_count + 1;
  end
endmodule : rtcptc_adc_model

// File: testbench/test_rtc_periodic_trigger_control.sv
`timescale 1ns/1ps
module test_rtc_periodic_trigger_control;
  logic                    clk = 1'b0;
  logic                    rst = 1'b1;
  rtcptc_pkg::rtcptc_req_t req = '0;
  logic [31:0]             rdata, v, w;
  logic                    irq_to_cpu, converter_trigger, converter_comparator_enable;
  logic [1:0]              irq_priority, t;
  rtcptc_pkg::rtcptc_ctrl_t cc;
  int                      bad_count = 0, check_count = 0, cycles = 0, convs, n;
  int                      seed = 32'hA078CB33;
  always #25 clk = ~clk;
  rtcptc_top #(.SECOND_CYCLES(20)) dut (.clk(clk), .rst(rst), .req(req), .rdata(rdata),
    .irq_to_cpu(irq_to_cpu), .irq_priority(irq_priority), .converter_trigger(converter_trigger),
    .converter_comparator_enable(converter_comparator_enable));
  rtcptc_adc_model adc (.clk(clk), .rst(rst), .trigger(converter_trigger),
    .comparator_enable(converter_comparator_enable), .conv_count(convs));
  function automatic logic [31:0] ctrl(input logic g, r, m, wq, input logic [1:0] tr);
    rtcptc_pkg::rtcptc_ctrl_t c;
    c = rtcptc_pkg::CTRL_RESET;
    c = '{converter_comparator_enable: 1'b1, converter_trigger_source_sel: tr,
      periodic_irq_period_sel: rtcptc_pkg::PERIOD_SECOND, timekeeper_irq_priority_hi: 1'b1,
      timekeeper_irq_priority_lo: 1'b1, timekeeper_irq_mask: m, counter_wait_request: wq,
      timekeeper_run: r, timekeeper_clock_gate: g};
    return {20'h0, c};
  endfunction : ctrl
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    req <= '0;
  endtask : wr
  task rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge clk);
    req <= '0;
    #1 d = rdata;
  endtask : rd
  task wait_trig();
    n = 0;
    do begin
      @(posedge clk);
      #1 n++;
    end while (converter_trigger !== 1'b1 && n < 100);
  endtask : wait_trig
  task poll(input logic want);
    n = 0;
    do begin
      rd(rtcptc_pkg::OFF_STATUS, v);
      n++;
    end while (v[1] !== want && n < 10);
  endtask : poll
  task results();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : results
  // ceiling is more than ten times the length of the sequence below
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      results();
    end
  end
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rd(rtcptc_pkg::OFF_CTRL, v);
    check("ctrl_reset", v, 32'h0);
    wr(4'hC, $random(seed));
    rd(4'hC, v);
    check("unmapped", v, 32'h0);
    wr(rtcptc_pkg::OFF_STATUS, 32'h0);
    wr(rtcptc_pkg::OFF_CTRL, ctrl(1'b0, 1'b1, 1'b0, 1'b0, rtcptc_pkg::TRIG_TIMEKEEPER));
    repeat (50) @(posedge clk);
    #1 check("gated_convs", convs, 0);
    check("comparator_on", converter_comparator_enable, 1'b1);
    wr(rtcptc_pkg::OFF_CTRL, ctrl(1'b1, 1'b0, 1'b0, 1'b0, rtcptc_pkg::TRIG_TIMEKEEPER));
    repeat (50) @(posedge clk);
    #1 check("stopped_convs", convs, 0);
    check("priority", irq_priority, 2'h3);
    // comparator is already on, run comes last
    wr(rtcptc_pkg::OFF_CTRL, ctrl(1'b1, 1'b1, 1'b0, 1'b0, rtcptc_pkg::TRIG_TIMEKEEPER));
    wait_trig();
    check("first_event", n <= 21, 1'b1);
    wait_trig();
    check("period", n, 20);
    @(posedge clk);
    #1 check("irq_unmasked", irq_to_cpu, 1'b1);
    rd(rtcptc_pkg::OFF_STATUS, v);
    check("flag_set", v[0], 1'b1);
    wr(rtcptc_pkg::OFF_STATUS, 32'h0);
    rd(rtcptc_pkg::OFF_STATUS, v);
    check("flag_clear", v[0], 1'b0);
    wr(rtcptc_pkg::OFF_CTRL, ctrl(1'b1, 1'b1, 1'b1, 1'b0, rtcptc_pkg::TRIG_TIMEKEEPER));
    wr(rtcptc_pkg::OFF_STATUS, 32'h0);
    w = convs;
    wait_trig();
    check("masked_trigger", n <= 20, 1'b1);
    repeat (3) @(posedge clk);
    #1 check("irq_masked", irq_to_cpu, 1'b0);
    check("masked_conv", convs, w + 32'h1);
    for (int i = 0; i < 3; i++) begin
      t = 2'($random(seed));
      if (t == rtcptc_pkg::TRIG_TIMEKEEPER) t = 2'h3;
      wr(rtcptc_pkg::OFF_CTRL, ctrl(1'b1, 1'b1, 1'b1, 1'b0, t));
      n = convs;
      repeat (45) @(posedge clk);
      #1 check("other_source", convs, n);
    end
    wr(rtcptc_pkg::OFF_CTRL, ctrl(1'b1, 1'b1, 1'b0, 1'b1, rtcptc_pkg::TRIG_TIMEKEEPER));
    poll(1'b1);
    check("wait_on", v[1], 1'b1);
    rd(rtcptc_pkg::OFF_COUNT, v);
    repeat (45) @(posedge clk);
    rd(rtcptc_pkg::OFF_COUNT, w);
    check("count_frozen", w, v);
    wr(rtcptc_pkg::OFF_CTRL, ctrl(1'b1, 1'b1, 1'b0, 1'b0, rtcptc_pkg::TRIG_TIMEKEEPER));
    poll(1'b0);
    check("wait_off", v[1], 1'b0);
    repeat (45) @(posedge clk);
    rd(rtcptc_pkg::OFF_COUNT, v);
    check("count_resumed", v != w, 1'b1);
    // half-second code: events land at both prescaler marks, half a second apart
    v = ctrl(1'b1, 1'b1, 1'b0, 1'b0, rtcptc_pkg::TRIG_TIMEKEEPER);
    cc = v[11:0];
    cc.periodic_irq_period_sel = rtcptc_pkg::PERIOD_HALF;
    wr(rtcptc_pkg::OFF_CTRL, {20'h00000, cc});
    wait_trig();
    wait_trig();
    check("half_period", n, 10);
    cc.periodic_irq_period_sel = 3'h0;
    wr(rtcptc_pkg::OFF_CTRL, {20'h00000, cc});
    n = convs;
    repeat (45) @(posedge clk);
    #1 check("period_off", convs, n);
    results();
  end
endmodule : test_rtc_periodic_trigger_control
